//--- verilog/pksf_pkg.sv
// constants for the public key unit status and flag logic
// assumes a 32-bit register port with word-aligned byte offsets
package pksf_pkg;

  // register byte offsets
  localparam logic [3:0] PKSF_OFF_CONTROL = 4'h0;
  localparam logic [3:0] PKSF_OFF_STATUS = 4'h4;
  localparam logic [3:0] PKSF_OFF_MASK = 4'h8;
  localparam logic [3:0] PKSF_OFF_EXP_FEED = 4'hc;

  // status bits on the data bus, bit 0 of the register is the msb
  localparam int PKSF_ST_EXP_READY = 4;
  localparam int PKSF_ST_IRQ = 3;
  localparam int PKSF_ST_OOB = 2;
  localparam int PKSF_ST_GEN_ERR = 1;
  localparam int PKSF_ST_DONE = 0;
  localparam logic [4:0] PKSF_IRQ_SOURCES = 5'h17;

  // control bits on the data bus, same msb-first numbering
  localparam int PKSF_CT_SOFT_RESET = 5;
  localparam int PKSF_CT_IRQ_ENABLE = 4;
  localparam int PKSF_CT_GO = 3;

  // reset values
  localparam logic [15:0] PKSF_CONTROL_RST = 16'h0000;
  localparam logic [4:0] PKSF_STATUS_RST = 5'h00;
  localparam logic [4:0] PKSF_MASK_RST = 5'h00;
  localparam logic [31:0] PKSF_FEED_RST = 32'h0000_0000;

  // length of the clear-all boot routine, one cycle per ram word
  localparam int PKSF_CLEAR_WORDS = 256;
  localparam logic [8:0] PKSF_BOOT_LAST = 9'(PKSF_CLEAR_WORDS - 1);

  typedef enum logic [1:0] {
    PKSF_BOOT = 2'b00,
    PKSF_IDLE = 2'b01,
    PKSF_RUN = 2'b10
  } pksf_state_t;

endpackage : pksf_pkg

//--- verilog/pksf_status.sv
// status register, flag and interrupt logic of the public key unit
// assumes the sequencer reports jumps to location 0, errors and word
// consumption as one-cycle pulses synchronous to CLK
//
// How it works
// - an error during operation sets its status flag to one
// - after go, the first jump to location 0 sets done, then interrupt
// - status ignores written data; any status write clears all flags
// - exponent-ready rises in run when the datapath takes its working word, leaving room for the next 32-bit word
// - a feed write clears exponent-ready and its interrupt cause
// - interrupt drops about two cycles after the feed write
// - feed is double-buffered; host refills within eight multiplies
// - interrupt status bit drives the pin, set even with enable clear
// - access to an unknown address sets out-of-bounds; read data zero
// - any error without its own flag sets the general-error flag
// - done is set on every branch to location 0 outside boot
// - after reset the unit clears ram while busy, then sets done
// - status bits: exp-ready 11, irq 12, oob 13, error 14, done 15
// - with global enable clear the interrupt pin stays at 0
// - a masked flag raises no interrupt; unmasked ones do when enabled
// - soft reset restores registers, halts, clears irq, reruns clear-all
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module pksf_status
  import pksf_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic JUMP_ZERO,
  input wire logic UNIT_ERR,
  input wire logic GEN_ERR,
  input wire logic FEED_TAKE,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic BUSY,
  output logic RUNNING,
  output logic CLEAR_RAM,
  output logic [15:0] UNIT_CONTROL,
  output logic [31:0] FEED_WORD,
  output logic FEED_VALID
);

  // register state
  pksf_state_t state;
  pksf_state_t next_state;
  logic [8:0] boot_cnt;
  logic [8:0] next_boot_cnt;
  logic [15:0] control;
  logic [15:0] next_control;
  logic [4:0] status;
  logic [4:0] next_status;
  logic [4:0] mask;
  logic [4:0] next_mask;
  logic [31:0] feed_hold;
  logic [31:0] next_feed_hold;
  logic hold_full;
  logic next_hold_full;
  logic [31:0] feed_work;
  logic [31:0] next_feed_work;
  logic work_full;
  logic next_work_full;
  logic irq_pin;
  logic next_irq_pin;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic soft_rst;
  logic next_soft_rst;
  logic busy;
  logic next_busy;
  logic clear_ram;
  logic next_clear_ram;

  // decoded accesses
  logic hit_control;
  logic hit_status;
  logic hit_mask;
  logic hit_feed;
  logic mapped;
  logic oob_event;
  logic err_event;
  logic gen_event;
  logic done_event;
  logic ready_event;
  logic feed_wr;
  logic irq_cause;

  // address decode, shared by the processes below
  always_comb begin
    hit_control = (ADDR == PKSF_OFF_CONTROL);
    hit_status = (ADDR == PKSF_OFF_STATUS);
    hit_mask = (ADDR == PKSF_OFF_MASK);
    hit_feed = (ADDR == PKSF_OFF_EXP_FEED);
    mapped = hit_control | hit_status | hit_mask | hit_feed;
    oob_event = (WR | RD) & ~mapped;
    feed_wr = WR & hit_feed;
  end

  // event sources feeding the sticky flags
  always_comb begin
    // a dedicated error reported by the sequencer
    err_event = UNIT_ERR;
    // errors nobody else flags: feed overrun and go during boot
    gen_event = GEN_ERR
      | (feed_wr & hold_full & work_full & ~FEED_TAKE)
      | (WR & hit_control & WDATA[PKSF_CT_GO] & (state == PKSF_BOOT));
    // every branch to location 0 outside boot, plus the end of the boot routine
    done_event = JUMP_ZERO & (state != PKSF_BOOT);
    if ((state == PKSF_BOOT) && (boot_cnt == PKSF_BOOT_LAST)) begin
      done_event = 1'b1;
    end
    // the datapath taking its working word in run leaves room for the next one
    ready_event = (state == PKSF_RUN) & FEED_TAKE & work_full
      & ~(hold_full & feed_wr);
  end

  // sequencing: boot, idle and run
  always_comb begin
    next_state = state;
    next_boot_cnt = boot_cnt;
    case (state)
      PKSF_BOOT: begin
        next_boot_cnt = boot_cnt + 9'h001;
        if (boot_cnt == PKSF_BOOT_LAST) begin
          next_state = PKSF_IDLE;
          next_boot_cnt = 9'h000;
        end
      end
      PKSF_IDLE: begin
        if (WR && hit_control && WDATA[PKSF_CT_GO]) begin
          next_state = PKSF_RUN;
        end
      end
      PKSF_RUN: begin
        if (JUMP_ZERO) begin
          next_state = PKSF_IDLE;
        end
      end
      default: begin
        next_state = PKSF_BOOT;
        next_boot_cnt = 9'h000;
      end
    endcase
    // state decodes registered so the pins come straight from flops
    next_busy = (next_state != PKSF_IDLE);
    next_clear_ram = (next_state == PKSF_BOOT);
  end

  // control and mask registers
  always_comb begin
    next_control = control;
    next_mask = mask;
    next_soft_rst = 1'b0;
    if (WR && hit_control) begin
      next_control = WDATA[15:0];
      next_soft_rst = WDATA[PKSF_CT_SOFT_RESET];
      next_control[PKSF_CT_SOFT_RESET] = 1'b0;
      // go is taken only in idle, so a go during boot cannot stick
      if (state != PKSF_IDLE) begin
        next_control[PKSF_CT_GO] = control[PKSF_CT_GO];
      end
    end
    // go reads back as running, cleared by the stop at location 0
    if (JUMP_ZERO && (state == PKSF_RUN)) begin
      next_control[PKSF_CT_GO] = 1'b0;
    end
    if (WR && hit_mask) begin
      next_mask = WDATA[4:0];
    end
  end

  // sticky status flags: a set in the same cycle as a clear wins
  always_comb begin
    next_status = status;
    if (WR && hit_status) begin
      next_status = PKSF_STATUS_RST;
    end
    // go restarts the completion report
    if (WR && hit_control && WDATA[PKSF_CT_GO] && (state == PKSF_IDLE)) begin
      next_status[PKSF_ST_DONE] = 1'b0;
    end
    if (feed_wr) begin
      next_status[PKSF_ST_EXP_READY] = 1'b0;
    end
    if (ready_event) begin
      next_status[PKSF_ST_EXP_READY] = 1'b1;
    end
    if (oob_event) begin
      next_status[PKSF_ST_OOB] = 1'b1;
    end
    if (err_event) begin
      next_status[PKSF_ST_GEN_ERR] = 1'b1;
    end
    if (gen_event) begin
      next_status[PKSF_ST_GEN_ERR] = 1'b1;
    end
    if (done_event) begin
      next_status[PKSF_ST_DONE] = 1'b1;
    end
    // the irq bit follows the unmasked causes, whatever the enable says
    next_status[PKSF_ST_IRQ] = irq_cause;
  end

  // interrupt: the cause is taken from registered flags, the pin one
  // edge later, so a feed write shows at the pin two edges after it
  always_comb begin
    irq_cause = |(status & ~mask & PKSF_IRQ_SOURCES);
    next_irq_pin = status[PKSF_ST_IRQ] & control[PKSF_CT_IRQ_ENABLE];
  end

  // double-buffered exponent feed
  always_comb begin
    next_feed_hold = feed_hold;
    next_hold_full = hold_full;
    next_feed_work = feed_work;
    next_work_full = work_full;
    // the datapath drops its working word when it takes it
    if (FEED_TAKE && work_full) begin
      next_work_full = 1'b0;
    end
    // the held word moves on as soon as the working side is free
    if (hold_full && (!work_full || FEED_TAKE)) begin
      next_feed_work = feed_hold;
      next_work_full = 1'b1;
      next_hold_full = 1'b0;
    end
    // a host word lands in the free half; overrun is dropped
    if (feed_wr) begin
      if (!next_hold_full && next_work_full) begin
        next_feed_hold = WDATA;
        next_hold_full = 1'b1;
      end else if (!next_work_full) begin
        next_feed_work = WDATA;
        next_work_full = 1'b1;
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (RD) begin
      if (hit_control) begin
        next_rdata = {16'h0000, control};
      end else if (hit_status) begin
        next_rdata = {27'h000_0000, status};
      end else if (hit_mask) begin
        next_rdata = {27'h000_0000, mask};
      end
    end
  end

  // all state registers; soft reset acts like the system reset
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      state <= PKSF_BOOT;
      boot_cnt <= 9'h000;
      control <= PKSF_CONTROL_RST;
      status <= PKSF_STATUS_RST;
      mask <= PKSF_MASK_RST;
      feed_hold <= PKSF_FEED_RST;
      hold_full <= 1'b0;
      feed_work <= PKSF_FEED_RST;
      work_full <= 1'b0;
      irq_pin <= 1'b0;
      rdata <= 32'h0000_0000;
      soft_rst <= 1'b0;
      busy <= 1'b1;
      clear_ram <= 1'b1;
    end else begin
      state <= next_state;
      boot_cnt <= next_boot_cnt;
      control <= next_control;
      status <= next_status;
      mask <= next_mask;
      feed_hold <= next_feed_hold;
      hold_full <= next_hold_full;
      feed_work <= next_feed_work;
      work_full <= next_work_full;
      irq_pin <= next_irq_pin;
      rdata <= next_rdata;
      soft_rst <= next_soft_rst;
      busy <= next_busy;
      clear_ram <= next_clear_ram;
    end
  end

  // outputs, each straight from a flip-flop
  always_comb begin
    RDATA = rdata;
    IRQ = irq_pin;
    BUSY = busy;
    RUNNING = control[PKSF_CT_GO];
    CLEAR_RAM = clear_ram;
    UNIT_CONTROL = control;
    FEED_WORD = feed_work;
    FEED_VALID = work_full;
  end

endmodule : pksf_status

//--- tb/pksf_status_props.sv
// checker for the status flag block, sees the top module's ports only
// assumes the one clock and the synchronous active-high reset
`timescale 1ns/1ps

module pksf_status_props
  import pksf_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic JUMP_ZERO,
  input wire logic [31:0] RDATA,
  input wire logic IRQ,
  input wire logic BUSY,
  input wire logic RUNNING,
  input wire logic CLEAR_RAM,
  input wire logic [15:0] UNIT_CONTROL,
  input wire logic [31:0] FEED_WORD,
  input wire logic FEED_VALID
);
  logic [8:0] boot_cycles;
  logic [8:0] next_boot_cycles;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ram clearing cycles, restarted whenever CLEAR_RAM is low, so a soft reset from idle or run is timed too
  always_comb next_boot_cycles = CLEAR_RAM ? boot_cycles + 9'h001 : 9'h000;
  always_ff @(posedge CLK) boot_cycles <= SYS_RST ? 9'h000 : next_boot_cycles;

  a_boot_length: assert property ($fell(CLEAR_RAM) |-> boot_cycles == 9'h100)
    else $error("boot length wrong");
  a_irq_needs_enable: assert property (!$past(UNIT_CONTROL[PKSF_CT_IRQ_ENABLE]) |-> !IRQ)
    else $error("irq without enable");
  a_oob_read_zero: assert property (RD && ADDR[1:0] != 2'b00 |=> RDATA == 32'h0)
    else $error("oob read data");
  a_status_width: assert property (RD && ADDR == 4'h4 |=> RDATA[31:5] == 27'h0)
    else $error("status reserved bits");
  a_go_starts_run: assert property (WR && ADDR == 4'h0 && WDATA[PKSF_CT_GO]
    && !WDATA[PKSF_CT_SOFT_RESET] && !BUSY |=> RUNNING)
    else $error("go ignored");
  a_run_ends_zero: assert property (RUNNING && JUMP_ZERO |=> !RUNNING)
    else $error("run not ended");
  a_soft_reset_boot: assert property (WR && ADDR == 4'h0 && WDATA[PKSF_CT_SOFT_RESET]
    |-> ##3 CLEAR_RAM && !RUNNING && !IRQ)
    else $error("soft reset failed");
  a_feed_first_word: assert property (WR && ADDR == 4'hc && !FEED_VALID
    |=> FEED_VALID && FEED_WORD == $past(WDATA))
    else $error("feed word lost");

  // main scenarios reached
  cover property (RUNNING && JUMP_ZERO);
  cover property ($rose(IRQ));
  cover property ($fell(CLEAR_RAM));
endmodule : pksf_status_props

bind pksf_status pksf_status_props u_props (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .JUMP_ZERO(JUMP_ZERO), .RDATA(RDATA), .IRQ(IRQ), .BUSY(BUSY), .RUNNING(RUNNING),
  .CLEAR_RAM(CLEAR_RAM), .UNIT_CONTROL(UNIT_CONTROL), .FEED_WORD(FEED_WORD),
  .FEED_VALID(FEED_VALID)
);

//--- tb/pksf_seq_model.sv
// sequencer and datapath model on the far side of the flag block
// assumes RUNNING marks a routine in progress
`timescale 1ns/1ps

module pksf_seq_model (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RUNNING,
  input wire logic FEED_VALID,
  output logic JUMP_ZERO,
  output logic FEED_TAKE
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // run cycle count, held at zero while idle
  always_comb next_cnt = RUNNING ? cnt + 8'h01 : 8'h00;
  always_ff @(posedge CLK) cnt <= SYS_RST ? 8'h00 : next_cnt;

  // a word every 32 cycles, slow so the second buffer half gets tested
  assign FEED_TAKE = (RUNNING === 1'b1) && (FEED_VALID === 1'b1) && (cnt[4:0] == 5'h1f);
  assign JUMP_ZERO = (RUNNING === 1'b1) && (cnt == 8'hc0);
endmodule : pksf_seq_model

//--- tb/test_pke_status_flags.sv
// self-checking bench for the status flag block
// assumes the package, the design and the sequencer model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end

module test_pke_status_flags;
  logic CLK = 1'b0;
  logic SYS_RST, WR, RD, UNIT_ERR, GEN_ERR, IRQ, BUSY, RUNNING, CLEAR_RAM, FEED_VALID;
  logic JUMP_ZERO, FEED_TAKE;
  logic rd_seen = 1'b0;
  logic [3:0] ADDR;
  logic [31:0] WDATA, RDATA, FEED_WORD, e;
  logic [15:0] UNIT_CONTROL;
  logic [31:0] note[$];
  int fails = 0;
  int comparisons = 0;

  always #2.5 CLK = ~CLK;

  pksf_status u_pksf_status (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .JUMP_ZERO(JUMP_ZERO), .UNIT_ERR(UNIT_ERR), .GEN_ERR(GEN_ERR),
    .FEED_TAKE(FEED_TAKE), .RDATA(RDATA), .IRQ(IRQ), .BUSY(BUSY), .RUNNING(RUNNING),
    .CLEAR_RAM(CLEAR_RAM), .UNIT_CONTROL(UNIT_CONTROL), .FEED_WORD(FEED_WORD),
    .FEED_VALID(FEED_VALID));
  pksf_seq_model u_pksf_seq_model (.CLK(CLK), .SYS_RST(SYS_RST), .RUNNING(RUNNING),
    .FEED_VALID(FEED_VALID), .JUMP_ZERO(JUMP_ZERO), .FEED_TAKE(FEED_TAKE));

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // gap cycle after each strobe so no signal is assigned twice in a step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    note.push_back(x);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 0;
    @(posedge CLK);
  endtask : rd

  // settle flag and irq bit before looking at status
  task automatic st(input logic [31:0] x);
    repeat (3) @(posedge CLK);
    rd(4'h4, x);
  endtask : st

  // read data stands one cycle after the strobe only
  always @(posedge CLK) begin
    if (rd_seen) begin
      e = note.pop_front();
      `CHK("RDATA", e, RDATA)
    end
    rd_seen <= RD;
  end

  initial begin
    #50000;
    fails++;
    give_verdict();
  end

  initial begin
    void'($urandom(47));
    SYS_RST = 1'b1;
    ADDR = 4'h0;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    UNIT_ERR = 1'b0;
    GEN_ERR = 1'b0;
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    #1 `CHK("BUSY", 1'b1, BUSY)
    for (int i = 0; i < 300 && BUSY !== 1'b0; i++) @(posedge CLK);
    st(32'h09);
    rd(4'h0, 32'h0);
    wr(4'h4, $urandom);
    st(32'h0);
    rd({2'($urandom), 2'($urandom_range(3, 1))}, 32'h0);
    st(32'h0c);
    wr(4'h4, 32'h0);
    UNIT_ERR <= 1'b1;
    @(posedge CLK);
    UNIT_ERR <= 1'b0;
    st(32'h0a);
    wr(4'h4, $urandom);
    GEN_ERR <= 1'b1;
    @(posedge CLK);
    GEN_ERR <= 1'b0;
    st(32'h0a);
    `CHK("IRQ", 1'b0, IRQ)
    wr(4'h0, 32'h10);
    #1 `CHK("IRQ", 1'b1, IRQ)
    `CHK("UNIT_CONTROL", 16'h0010, UNIT_CONTROL)
    wr(4'h8, 32'h02);
    repeat (2) @(posedge CLK);
    #1 `CHK("IRQ", 1'b0, IRQ)
    // run with nothing fed, ends at the jump to zero
    wr(4'h8, 32'h10);
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h18);
    for (int i = 0; i < 300 && RUNNING !== 1'b0; i++) @(posedge CLK);
    st(32'h09);
    `CHK("IRQ", 1'b1, IRQ)
    // only exponent-ready may interrupt now
    wr(4'h8, 32'h07);
    rd(4'h8, 32'h07);
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h18);
    wr(4'hc, $urandom);
    wr(4'hc, $urandom);
    for (int i = 0; i < 100 && IRQ !== 1'b1; i++) @(posedge CLK);
    st(32'h18);
    wr(4'hc, $urandom);
    #1 `CHK("IRQ", 1'b1, IRQ)
    @(posedge CLK);
    #1 `CHK("IRQ", 1'b0, IRQ)
    // soft reset in mid-run halts and reboots
    wr(4'h0, 32'h20);
    @(posedge CLK);
    #1 `CHK("RUNNING", 1'b0, RUNNING)
    // go during boot is refused and counts as a general error
    wr(4'h0, 32'h08);
    for (int i = 0; i < 300 && BUSY !== 1'b0; i++) @(posedge CLK);
    st(32'h0b);
    `CHK("RUNNING", 1'b0, RUNNING)
    rd(4'h8, 32'h0);
    repeat (3) @(posedge CLK);
    give_verdict();
  end
endmodule : test_pke_status_flags
